// ### sbsr_pkg.sv
// Functional notes
// - Master summary at bit 6 is the OR of the other seven bits masked by service enable.
// - A serial poll answer carries the request-service flag in bit 6 instead.
// - The request-service flag clears once a serial poll of the device completes.
// - A status query answer carries the master summary flag in bit 6.
// - Reading the byte by either method leaves every summary flag unchanged.
// - Event summary at bit 5 is the OR of standard event latch bits masked by their enables.
// - Hardware summary at bit 0 is the OR of hardware event latch bits masked by enables.
// - Output-available at bit 4 is high while response bytes wait and low once empty.
// - Measurement-done at bit 1 sets on finish and clears on measurement clear or start.
// - Both reads return the byte with bit 7 weighing 128 down to bit 0 weighing 1.
// - Service enable read back always shows bit 6 as zero.
// - Clear-status clears event latches and their summaries, not output or measurement flags.
package sbsr_pkg;
  localparam int SBSR_HW_BIT = 0;
  localparam int SBSR_MEAS_BIT = 1;
  localparam int SBSR_OUT_BIT = 4;
  localparam int SBSR_EVT_BIT = 5;
  localparam int SBSR_MSS_BIT = 6;
  localparam logic [7:0] SBSR_USED_MASK = 8'h33;
  localparam logic [7:0] SBSR_ENA_MASK = 8'hBF;
  localparam logic [7:0] SBSR_BYTE_RESET = 8'h00;
  localparam int SBSR_STD_W = 16;
  localparam int SBSR_HW_W = 16;
endpackage

// ### sbsr_mask_or.sv
`timescale 1ns/100ps
`default_nettype none
module sbsr_mask_or #(
  parameter int W = 16
) (
  input wire logic [W-1:0] latch_in,
  input wire logic [W-1:0] enable_in,
  output logic any_out
);
  assign any_out = |(latch_in & enable_in);
endmodule
`default_nettype wire

// ### sbsr_status_byte.sv
`timescale 1ns/100ps
`default_nettype none
module sbsr_status_byte
  import sbsr_pkg::*;
#(
  parameter int STD_W = SBSR_STD_W,
  parameter int HW_W = SBSR_HW_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [STD_W-1:0] std_event_in,
  input wire logic [STD_W-1:0] std_enable_in,
  input wire logic [HW_W-1:0] hw_event_in,
  input wire logic [HW_W-1:0] hw_enable_in,
  input wire logic [7:0] srv_enable_in,
  input wire logic srv_enable_we_in,
  input wire logic out_pending_in,
  input wire logic meas_finish_in,
  input wire logic meas_clear_in,
  input wire logic meas_start_in,
  input wire logic clear_status_in,
  input wire logic poll_done_in,
  output logic [7:0] poll_byte_out,
  output logic [7:0] query_byte_out,
  output logic [7:0] srv_enable_out,
  output logic srq_out,
  output logic [STD_W-1:0] std_event_latch_out,
  output logic [HW_W-1:0] hw_event_latch_out
);
  //////////////////////////////////////////////////////////////////////////////
  logic [STD_W-1:0] std_r, std_nxt;
  logic [HW_W-1:0] hw_r, hw_nxt;
  logic [7:0] ena_r, ena_nxt;
  logic meas_r, meas_nxt;
  logic out_r, out_nxt;
  logic rqs_r, rqs_nxt;
  logic mss_prev_r, mss_prev_nxt;
  logic [7:0] poll_r, poll_nxt, query_r, query_nxt;
  logic evt_sum, hw_sum, master_summary_flag;
  logic [7:0] sum_byte;

  //////////////////////////////////////////////////////////////////////////////
  // Byte image with bit 6 taken from the chosen flag
  function automatic logic [7:0] put_bit6(input logic [7:0] b, input logic v);
    logic [7:0] r;
    r = b;
    r[SBSR_MSS_BIT] = v;
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Event and hardware summary masks
  sbsr_mask_or #(.W(STD_W)) u_std (
    .latch_in(std_r),
    .enable_in(std_enable_in),
    .any_out(evt_sum)
  );
  sbsr_mask_or #(.W(HW_W)) u_hw (
    .latch_in(hw_r),
    .enable_in(hw_enable_in),
    .any_out(hw_sum)
  );

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    sum_byte = SBSR_BYTE_RESET;
    sum_byte[SBSR_HW_BIT] = hw_sum;
    sum_byte[SBSR_MEAS_BIT] = meas_r;
    sum_byte[SBSR_OUT_BIT] = out_r;
    sum_byte[SBSR_EVT_BIT] = evt_sum;
    sum_byte = sum_byte & SBSR_USED_MASK;
    master_summary_flag = |(sum_byte & ena_r & SBSR_ENA_MASK);
  end

  always_comb begin
    // Clear-status hits event latches only; new events win
    std_nxt = (clear_status_in ? '0 : std_r) | std_event_in;
    hw_nxt = (clear_status_in ? '0 : hw_r) | hw_event_in;
    ena_nxt = srv_enable_we_in ? (srv_enable_in & SBSR_ENA_MASK) : ena_r;
    meas_nxt = meas_r;
    if (meas_clear_in || meas_start_in) begin
      meas_nxt = 1'b0;
    end
    if (meas_finish_in) begin
      meas_nxt = 1'b1;
    end
    out_nxt = out_pending_in;
    mss_prev_nxt = master_summary_flag;
    rqs_nxt = rqs_r;
    if (poll_done_in) begin
      rqs_nxt = 1'b0;
    end
    if (master_summary_flag && !mss_prev_r) begin
      rqs_nxt = 1'b1;
    end
    poll_nxt = put_bit6(sum_byte, rqs_r);
    query_nxt = put_bit6(sum_byte, master_summary_flag);
  end

  // Reads leave flags alone, except that a completed poll clears the request flag
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      std_r <= '0;
      hw_r <= '0;
      ena_r <= SBSR_BYTE_RESET;
      meas_r <= 1'b0;
      out_r <= 1'b0;
      rqs_r <= 1'b0;
      mss_prev_r <= 1'b0;
      poll_r <= SBSR_BYTE_RESET;
      query_r <= SBSR_BYTE_RESET;
    end else begin
      std_r <= std_nxt;
      hw_r <= hw_nxt;
      ena_r <= ena_nxt;
      meas_r <= meas_nxt;
      out_r <= out_nxt;
      rqs_r <= rqs_nxt;
      mss_prev_r <= mss_prev_nxt;
      poll_r <= poll_nxt;
      query_r <= query_nxt;
    end
  end

  assign poll_byte_out = poll_r;
  assign query_byte_out = query_r;
  assign srv_enable_out = ena_r;
  assign srq_out = rqs_r;
  assign std_event_latch_out = std_r;
  assign hw_event_latch_out = hw_r;

  //////////////////////////////////////////////////////////////////////////////
  sequence s_rise;
    master_summary_flag && !mss_prev_r;
  endsequence

  // Poll completion with no new rising summary
  sequence s_poll_only;
    poll_done_in && !(master_summary_flag && !mss_prev_r);
  endsequence

  // Read with nothing else moving the flags
  sequence s_read_quiet;
    poll_done_in && !meas_finish_in && !meas_clear_in && !meas_start_in &&
      !clear_status_in && std_event_in == '0 && hw_event_in == '0;
  endsequence

  // Clear status with no new event arriving
  sequence s_cls_quiet;
    clear_status_in && std_event_in == '0 && hw_event_in == '0;
  endsequence

  //////////////////////////////////////////////////////////////////////////////
  // Byte composition
  chk_query_bit_six: assert property (@(posedge clk_in) disable iff (rst_in)
    1'b1 |=> query_byte_out[SBSR_MSS_BIT] == $past(master_summary_flag))
    else $error("query bit 6 not master summary");
  chk_poll_bit_six: assert property (@(posedge clk_in) disable iff (rst_in)
    1'b1 |=> poll_byte_out[SBSR_MSS_BIT] == $past(srq_out))
    else $error("poll bit 6 not request flag");
  chk_mss_form: assert property (@(posedge clk_in) disable iff (rst_in)
    query_byte_out[SBSR_MSS_BIT] == |(query_byte_out & $past(srv_enable_out) & SBSR_ENA_MASK))
    else $error("master summary not masked OR of byte");
  chk_byte_agree: assert property (@(posedge clk_in) disable iff (rst_in)
    (poll_byte_out & SBSR_ENA_MASK) == (query_byte_out & SBSR_ENA_MASK))
    else $error("poll and query bytes differ outside bit 6");
  chk_unused_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    (query_byte_out & ~(SBSR_USED_MASK | ~SBSR_ENA_MASK)) == 8'h00 &&
    (poll_byte_out & ~(SBSR_USED_MASK | ~SBSR_ENA_MASK)) == 8'h00)
    else $error("unused status bits set");
  chk_enable_six: assert property (@(posedge clk_in) disable iff (rst_in)
    srv_enable_out[SBSR_MSS_BIT] == 1'b0)
    else $error("enable bit 6 reads one");

  // Request flag
  chk_srq_rise: assert property (@(posedge clk_in) disable iff (rst_in)
    s_rise |=> srq_out)
    else $error("srq not set on rising summary");
  chk_srq_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    srq_out && !poll_done_in |=> srq_out)
    else $error("srq dropped without poll");
  chk_poll_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    s_poll_only |=> !srq_out)
    else $error("request flag not cleared by poll");

  // Flag sources
  chk_evt_summary: assert property (@(posedge clk_in) disable iff (rst_in)
    query_byte_out[SBSR_EVT_BIT] == |($past(std_event_latch_out) & $past(std_enable_in)))
    else $error("event summary not masked OR of latch");
  chk_hw_summary: assert property (@(posedge clk_in) disable iff (rst_in)
    query_byte_out[SBSR_HW_BIT] == |($past(hw_event_latch_out) & $past(hw_enable_in)))
    else $error("hardware summary not masked OR of latch");
  chk_meas_done: assert property (@(posedge clk_in) disable iff (rst_in)
    meas_finish_in |=> ##1 query_byte_out[SBSR_MEAS_BIT])
    else $error("measurement done not set");
  chk_meas_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (meas_clear_in || meas_start_in) && !meas_finish_in |=> ##1 !query_byte_out[SBSR_MEAS_BIT])
    else $error("measurement done not cleared");
  chk_out_avail: assert property (@(posedge clk_in) disable iff (rst_in)
    !out_pending_in |=> ##1 !query_byte_out[SBSR_OUT_BIT])
    else $error("output flag stays high on empty buffer");
  chk_out_set: assert property (@(posedge clk_in) disable iff (rst_in)
    out_pending_in |=> ##1 query_byte_out[SBSR_OUT_BIT])
    else $error("output flag not set while bytes wait");
  chk_cls_keep: assert property (@(posedge clk_in) disable iff (rst_in)
    clear_status_in && !meas_clear_in && !meas_start_in && meas_r |=> meas_r)
    else $error("clear status hit measurement flag");
  chk_cls_latch: assert property (@(posedge clk_in) disable iff (rst_in)
    s_cls_quiet |=> std_event_latch_out == '0 && hw_event_latch_out == '0)
    else $error("clear status left an event latch set");
  chk_read_keep: assert property (@(posedge clk_in) disable iff (rst_in)
    s_read_quiet |=> meas_r == $past(meas_r) &&
      std_event_latch_out == $past(std_event_latch_out) &&
      hw_event_latch_out == $past(hw_event_latch_out))
    else $error("read changed a summary flag");
endmodule
`default_nettype wire

// ### sbsr_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module sbsr_ctrl_model (
  input wire logic clk_in,
  input wire logic poll_in,
  input wire logic [3:0] lag_in,
  input wire logic [7:0] poll_byte_in,
  output logic poll_done_out,
  output logic [7:0] got_out,
  output logic busy_out
);
  initial {poll_done_out, got_out, busy_out} = '0;
  // Serial poll, prompt or slow
  always @(posedge clk_in) begin
    if (poll_in && !busy_out) begin
      busy_out <= 1'b1;
      repeat (lag_in) @(posedge clk_in);
      got_out <= poll_byte_in;
      poll_done_out <= 1'b1;
      @(posedge clk_in);
      poll_done_out <= 1'b0;
      busy_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### status_byte_service_request_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module status_byte_service_request_tb_top;
  logic clk_in = 0;
  logic rst_in = 1;
  logic [15:0] sev, sen, hev, hen;
  logic [7:0] srv, qb, pb, se, got;
  logic [15:0] sl, hl, eq[$];
  logic swe, outp, fin, mclr, mst, cls, pdone, srq, poll, busy;
  logic [3:0] lag;
  int sq[$];
  int fails = 0;
  int n_compared = 0;
  int k;
  string nm[6] = '{"query", "enable", "srq", "poll", "std latch", "hw latch"};
  event look;
  always #20 clk_in = ~clk_in;
  sbsr_status_byte u_sbsr_status_byte (.clk_in(clk_in), .rst_in(rst_in),
    .std_event_in(sev), .std_enable_in(sen), .hw_event_in(hev), .hw_enable_in(hen),
    .srv_enable_in(srv), .srv_enable_we_in(swe), .out_pending_in(outp),
    .meas_finish_in(fin), .meas_clear_in(mclr), .meas_start_in(mst),
    .clear_status_in(cls), .poll_done_in(pdone), .poll_byte_out(pb),
    .query_byte_out(qb), .srv_enable_out(se), .srq_out(srq),
    .std_event_latch_out(sl), .hw_event_latch_out(hl));
  sbsr_ctrl_model u_sbsr_ctrl_model (.clk_in(clk_in), .poll_in(poll), .lag_in(lag),
    .poll_byte_in(pb), .poll_done_out(pdone), .got_out(got), .busy_out(busy));
  ////////////////////////////////////////////////////////////////
  always @(look) begin : watch
    logic [15:0] e, g;
    int s;
    e = eq.pop_front();
    s = sq.pop_front();
    g = s == 0 ? {8'h00, qb} : s == 1 ? {8'h00, se} : s == 2 ? {15'h0000, srq} :
      s == 3 ? {8'h00, got} : s == 4 ? sl : hl;
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm[s], e, g);
    end
  end
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task exp_w(input int s, input logic [15:0] v);
    #1;
    eq.push_back(v);
    sq.push_back(s);
    -> look;
  endtask
  task exp(input int s, input logic [7:0] v);
    exp_w(s, {8'h00, v});
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task poll_it(input logic [7:0] v);
    cyc(1);
    lag <= 4'($urandom_range(6, 0));
    poll <= 1'b1;
    cyc(1);
    poll <= 1'b0;
    // Model raises busy on this edge; look after it has settled
    cyc(1);
    #1;
    for (k = 0; k < 30 && busy !== 1'b0; k++) begin
      cyc(1);
      #1;
    end
    if (busy !== 1'b0) begin
      fails++;
      close_out;
    end
    cyc(2);
    exp(3, v);
    exp(2, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {sev, sen, hev, hen, srv, swe, outp, fin, mclr, mst, cls, poll, lag} = '0;
    k = $urandom(48618);
    cyc(4);
    rst_in <= 1'b0;
    exp(0, 8'h00);
    cyc(1);
    srv <= 8'hFF;
    swe <= 1'b1;
    fin <= 1'b1;
    cyc(1);
    {swe, fin} <= '0;
    cyc(4);
    exp(1, 8'hBF);
    exp(0, 8'h42);
    exp(2, 8'h01);
    poll_it(8'h42);
    exp(0, 8'h42);
    $display("test poll done");
    for (int i = 0; i < 2; i++) begin
      cyc(1);
      fin <= 1'b1;
      cyc(1);
      fin <= 1'b0;
      cyc(3);
      mclr <= i == 0;
      mst <= i == 1;
      cyc(1);
      {mclr, mst} <= '0;
      cyc(4);
      exp(0, 8'h00);
    end
    $display("test measure done");
    cyc(1);
    hen <= 16'h0001 << $urandom_range(15, 0);
    sen <= 16'h0001 << $urandom_range(15, 0);
    cyc(1);
    hev <= hen;
    sev <= sen;
    {outp, fin} <= 2'b11;
    cyc(1);
    {hev, sev, fin} <= '0;
    cyc(4);
    exp(0, 8'h73);
    exp_w(4, sen);
    exp_w(5, hen);
    cyc(1);
    cls <= 1'b1;
    cyc(1);
    cls <= 1'b0;
    cyc(4);
    exp(0, 8'h52);
    exp_w(4, 16'h0000);
    exp_w(5, 16'h0000);
    cyc(1);
    // Event with its enable off leaves the summary low
    sev <= ~sen;
    cyc(1);
    sev <= '0;
    cyc(4);
    exp(0, 8'h52);
    exp_w(4, ~sen);
    $display("test events done");
    cyc(1);
    srv <= 8'h10;
    swe <= 1'b1;
    outp <= 1'b0;
    cyc(1);
    swe <= 1'b0;
    cyc(4);
    exp(0, 8'h02);
    exp(2, 8'h01);
    poll_it(8'h42);
    cyc(1);
    outp <= 1'b1;
    cyc(5);
    exp(2, 8'h01);
    poll_it(8'h52);
    $display("test request done");
    cyc(2);
    close_out;
  end
endmodule
`default_nettype wire
